// ==== src/eeprom_i2c_pkg.sv ====
// Purpose: Shared constants and types of the serial EEPROM slave
// Assumes: ref_clk at 10 MHz, SCL clocks the link side
// Notes: Device type code is arbitrary
package eeprom_i2c_pkg;
    // ****************************************
    // Geometry and select code
    // ****************************************
    localparam int ADDR_W_DEF = 12;
    localparam int PAGE_W_DEF = 5;
    // Arbitrary value, not a real maker code
    localparam logic [3:0] TYPE_ID_DEF = 4'h5;
    localparam int SEL_TYPE_LSB = 4;
    localparam int SEL_CE_LSB = 1;
    localparam int SEL_RW_BIT = 0;
    localparam logic RW_READ = 1'b1;
    // ****************************************
    // Bit slots within a byte frame
    // ****************************************
    localparam logic [3:0] BIT_FIRST = 4'h1;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    // ****************************************
    // Timing
    // ****************************************
    localparam longint CLK_PERIOD_NS = 100;
    localparam longint INTERNAL_PROGRAM_TIME_NS = 5000000;
    localparam int unsigned PROG_CYCLES_DEF =
        int'((INTERNAL_PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // ****************************************
    // State encodings
    // ****************************************
    typedef enum logic [5:0] {
        L_IDLE = 6'h01,
        L_SEL = 6'h02,
        L_ADDRH = 6'h04,
        L_ADDRL = 6'h08,
        L_WDATA = 6'h10,
        L_RDATA = 6'h20
    } link_state_t;
    typedef enum logic [1:0] {
        W_IDLE = 2'h1,
        W_PROG = 2'h2
    } prog_state_t;
endpackage : eeprom_i2c_pkg

// ==== src/serial_eeprom_i2c_slave.sv ====
// Purpose: I2C slave front end and write control of a serial EEPROM
// Assumes: SCL is the link clock; array and write timer on ref_clk
// Notes: SDA is open drain: sda_o low, sda_oe high pulls the line
// Behaviour
// - Protect pin high up to address end blocks all array changes
// - Floating protect pin reads low, writes allowed
// - Protected: select, addresses acked, data not
// - Reset ignores bus, leaves device idle
// - Select byte MSB first: type, enables, direction
// - Respond only when enables match strap pins
// - Direction bit one reads, zero writes
// - Match acks ninth bit; mismatch returns idle
// - Start is SDA fall with SCL high
// - Stop is SDA rise with SCL high
// - Receiver pulls SDA low in ninth slot
// - Sample SDA on every SCL rising edge
// - Write select then two acked address bytes
// - Sixteen bit address, high byte first
// - Protect seen from start to address end
// - Write starts only on stop in slot ten
// - Counter points past last written byte
// - Write cycle: no drive, all requests ignored
// - Byte write acked and stored unless protected
// - Random, current and sequential read sequences
// - Page write, in-page counter advances per byte
// - Reads ignore protect, counter increments and wraps
// - Master NoAck after read ends the transfer
module serial_eeprom_i2c_slave #(
    parameter int ADDR_W = eeprom_i2c_pkg::ADDR_W_DEF,
    parameter int PAGE_W = eeprom_i2c_pkg::PAGE_W_DEF,
    parameter logic [3:0] TYPE_ID = eeprom_i2c_pkg::TYPE_ID_DEF,
    parameter int unsigned PROG_CYCLES = eeprom_i2c_pkg::PROG_CYCLES_DEF
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic write_protect_n,
    input wire logic chip_sel_bit0,
    input wire logic chip_sel_bit1,
    input wire logic chip_sel_bit2,
    output logic write_busy
);
    localparam int DEPTH = 1 << ADDR_W;
    localparam int PAGE_BYTES = 1 << PAGE_W;

    function automatic logic sel_match(input logic [7:0] b, input logic [2:0] ce);
        sel_match = (b[7:eeprom_i2c_pkg::SEL_TYPE_LSB] == TYPE_ID) &&
            (b[eeprom_i2c_pkg::SEL_TYPE_LSB-1:eeprom_i2c_pkg::SEL_CE_LSB] == ce);
    endfunction : sel_match

    function automatic logic [ADDR_W-1:0] addr_next(input logic [ADDR_W-1:0] a);
        addr_next = a + 1'b1;
    endfunction : addr_next

    // ****************************************
    // Storage shared by both domains
    // ****************************************
    // Quasi-static crossing: the array is written only while the link
    // side is locked out, the page buffer read only in that window.
    logic [7:0] mem_q [0:DEPTH-1];
    logic [7:0] pbuf_q [0:PAGE_BYTES-1];
    logic [PAGE_BYTES-1:0] pvalid_q;

    // ****************************************
    // Start and stop detection
    // ****************************************
    logic start_tgl_q;
    logic stop_tgl_q;

    always_ff @(negedge sda_i or posedge rst) begin
        if (rst) begin
            start_tgl_q <= 1'b0;
        end else if (scl) begin
            start_tgl_q <= ~start_tgl_q;
        end
    end

    // Stop ends the frame while SCL stands still, so it must be caught here
    always_ff @(posedge sda_i or posedge rst) begin
        if (rst) begin
            stop_tgl_q <= 1'b0;
        end else if (scl) begin
            stop_tgl_q <= ~stop_tgl_q;
        end
    end

    // ****************************************
    // Link side on SCL
    // ****************************************
    eeprom_i2c_pkg::link_state_t state_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [7:0] rd_q;
    logic [7:0] addr_hi_q;
    logic [ADDR_W-1:0] addr_q;
    logic ack_q;
    logic rw_q;
    logic protect_q;
    logic armed_q;
    logic lock_q;
    logic lock_d;
    logic start_seen_q;
    logic stop_seen_q;
    logic done_s1_q;
    logic done_s2_q;
    logic done_seen_q;
    logic wp_s1_q;
    logic wp_s2_q;
    logic [2:0] ce_s1_q;
    logic [2:0] ce_s2_q;
    logic sda_oe_q;
    logic sda_o_q;
    logic done_tgl_q;
    logic start_pend;
    logic stop_pend;
    logic recv_state;
    logic in_header;
    logic data_take;
    logic drive_d;
    logic [7:0] full;
    logic [15:0] addr_full;

    assign start_pend = start_tgl_q ^ start_seen_q;
    assign stop_pend = stop_tgl_q ^ stop_seen_q;
    assign full = {shift_q[6:0], sda_i};
    assign addr_full = {addr_hi_q, full};
    assign in_header = (state_q == eeprom_i2c_pkg::L_SEL) ||
        (state_q == eeprom_i2c_pkg::L_ADDRH) || (state_q == eeprom_i2c_pkg::L_ADDRL);
    assign recv_state = in_header || (state_q == eeprom_i2c_pkg::L_WDATA);
    // Lock from a stop in slot ten until the write side reports done
    assign lock_d = (lock_q | (stop_pend & armed_q)) & ~(done_s2_q ^ done_seen_q);
    assign data_take = (state_q == eeprom_i2c_pkg::L_WDATA) && !start_pend &&
        (bit_cnt_q == eeprom_i2c_pkg::BIT_LAST) && !protect_q;

    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            wp_s1_q <= 1'b0;
            wp_s2_q <= 1'b0;
            ce_s1_q <= 3'h0;
            ce_s2_q <= 3'h0;
            done_s1_q <= 1'b0;
            done_s2_q <= 1'b0;
            done_seen_q <= 1'b0;
            lock_q <= 1'b0;
        end else begin
            // Floating protect pin is pulled low at the pad
            wp_s1_q <= write_protect_n;
            wp_s2_q <= wp_s1_q;
            ce_s1_q <= {chip_sel_bit2, chip_sel_bit1, chip_sel_bit0};
            ce_s2_q <= ce_s1_q;
            done_s1_q <= done_tgl_q;
            done_s2_q <= done_s1_q;
            done_seen_q <= done_s2_q;
            lock_q <= lock_d;
        end
    end

    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            state_q <= eeprom_i2c_pkg::L_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            rd_q <= 8'hFF;
            addr_hi_q <= 8'h00;
            addr_q <= '0;
            ack_q <= 1'b0;
            rw_q <= 1'b0;
            protect_q <= 1'b0;
            armed_q <= 1'b0;
            pvalid_q <= '0;
            start_seen_q <= 1'b0;
            stop_seen_q <= 1'b0;
        end else begin
            start_seen_q <= start_tgl_q;
            stop_seen_q <= stop_tgl_q;
            // Hold through the slot-ten rise, the one just before a stop
            armed_q <= armed_q & (lock_d | (state_q == eeprom_i2c_pkg::L_WDATA &&
                bit_cnt_q == 4'h0 && !start_pend));
            if (start_pend) begin
                protect_q <= wp_s2_q;
                bit_cnt_q <= eeprom_i2c_pkg::BIT_FIRST;
                shift_q <= {7'h00, sda_i};
                ack_q <= 1'b0;
                state_q <= lock_d ? eeprom_i2c_pkg::L_IDLE : eeprom_i2c_pkg::L_SEL;
            end else begin
                if (in_header) begin
                    protect_q <= protect_q | wp_s2_q;
                end
                if (recv_state && bit_cnt_q != eeprom_i2c_pkg::BIT_ACK) begin
                    shift_q <= full;
                    bit_cnt_q <= bit_cnt_q + 4'h1;
                end
                unique case (state_q)
                    eeprom_i2c_pkg::L_IDLE: begin
                        bit_cnt_q <= 4'h0;
                    end
                    eeprom_i2c_pkg::L_SEL: begin
                        if (bit_cnt_q == eeprom_i2c_pkg::BIT_LAST) begin
                            ack_q <= 1'b1;
                            rw_q <= full[eeprom_i2c_pkg::SEL_RW_BIT];
                            if (!sel_match(full, ce_s2_q)) begin
                                state_q <= eeprom_i2c_pkg::L_IDLE;
                            end
                        end else if (bit_cnt_q == eeprom_i2c_pkg::BIT_ACK) begin
                            bit_cnt_q <= 4'h0;
                            ack_q <= 1'b0;
                            if (rw_q == eeprom_i2c_pkg::RW_READ) begin
                                rd_q <= mem_q[addr_q];
                                state_q <= eeprom_i2c_pkg::L_RDATA;
                            end else begin
                                state_q <= eeprom_i2c_pkg::L_ADDRH;
                            end
                        end
                    end
                    eeprom_i2c_pkg::L_ADDRH: begin
                        if (bit_cnt_q == eeprom_i2c_pkg::BIT_LAST) begin
                            ack_q <= 1'b1;
                            addr_hi_q <= full;
                        end else if (bit_cnt_q == eeprom_i2c_pkg::BIT_ACK) begin
                            bit_cnt_q <= 4'h0;
                            ack_q <= 1'b0;
                            state_q <= eeprom_i2c_pkg::L_ADDRL;
                        end
                    end
                    eeprom_i2c_pkg::L_ADDRL: begin
                        if (bit_cnt_q == eeprom_i2c_pkg::BIT_LAST) begin
                            ack_q <= 1'b1;
                            addr_q <= addr_full[ADDR_W-1:0];
                            pvalid_q <= '0;
                        end else if (bit_cnt_q == eeprom_i2c_pkg::BIT_ACK) begin
                            bit_cnt_q <= 4'h0;
                            ack_q <= 1'b0;
                            state_q <= eeprom_i2c_pkg::L_WDATA;
                        end
                    end
                    eeprom_i2c_pkg::L_WDATA: begin
                        if (bit_cnt_q == eeprom_i2c_pkg::BIT_LAST) begin
                            ack_q <= !protect_q;
                            if (!protect_q) begin
                                pvalid_q[addr_q[PAGE_W-1:0]] <= 1'b1;
                            end
                        end else if (bit_cnt_q == eeprom_i2c_pkg::BIT_ACK) begin
                            bit_cnt_q <= 4'h0;
                            ack_q <= 1'b0;
                            // Only the next slot may hold the stop that arms a write
                            armed_q <= ack_q;
                            addr_q[PAGE_W-1:0] <= addr_q[PAGE_W-1:0] + 1'b1;
                        end
                    end
                    eeprom_i2c_pkg::L_RDATA: begin
                        if (bit_cnt_q == eeprom_i2c_pkg::BIT_ACK) begin
                            bit_cnt_q <= 4'h0;
                            if (sda_i) begin
                                state_q <= eeprom_i2c_pkg::L_IDLE;
                            end else begin
                                rd_q <= mem_q[addr_q];
                            end
                        end else begin
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                            if (bit_cnt_q == eeprom_i2c_pkg::BIT_LAST) begin
                                addr_q <= addr_next(addr_q);
                            end
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge scl) begin
        if (data_take) begin
            pbuf_q[addr_q[PAGE_W-1:0]] <= full;
        end
    end

    // Drive changes only while SCL is low
    assign drive_d = (recv_state && bit_cnt_q == eeprom_i2c_pkg::BIT_ACK && ack_q) ||
        (state_q == eeprom_i2c_pkg::L_RDATA && bit_cnt_q <= eeprom_i2c_pkg::BIT_LAST &&
        !rd_q[~bit_cnt_q[2:0]]);

    always_ff @(negedge scl or posedge rst) begin
        if (rst) begin
            sda_oe_q <= 1'b0;
            sda_o_q <= 1'b0;
        end else begin
            sda_oe_q <= drive_d & ~lock_q;
            sda_o_q <= 1'b0;
        end
    end

    assign sda_oe = sda_oe_q;
    assign sda_o = sda_o_q;

    // ****************************************
    // Write cycle on ref_clk
    // ****************************************
    eeprom_i2c_pkg::prog_state_t wstate_q;
    logic [31:0] timer_q;
    logic write_busy_q;
    logic stop_s1_q;
    logic stop_s2_q;
    logic stop_s3_q;
    logic armed_s1_q;
    logic armed_s2_q;
    logic commit;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stop_s1_q <= 1'b0;
            stop_s2_q <= 1'b0;
            stop_s3_q <= 1'b0;
            armed_s1_q <= 1'b0;
            armed_s2_q <= 1'b0;
        end else begin
            stop_s1_q <= stop_tgl_q;
            stop_s2_q <= stop_s1_q;
            stop_s3_q <= stop_s2_q;
            armed_s1_q <= armed_q;
            armed_s2_q <= armed_s1_q;
        end
    end

    // Armed is held by the lock, so it is still valid when the stop arrives
    assign commit = (wstate_q == eeprom_i2c_pkg::W_IDLE) &&
        (stop_s2_q ^ stop_s3_q) && armed_s2_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wstate_q <= eeprom_i2c_pkg::W_IDLE;
            timer_q <= 32'h0;
            write_busy_q <= 1'b0;
            done_tgl_q <= 1'b0;
        end else begin
            unique case (wstate_q)
                eeprom_i2c_pkg::W_IDLE: begin
                    if (commit) begin
                        wstate_q <= eeprom_i2c_pkg::W_PROG;
                        timer_q <= 32'(PROG_CYCLES - 1);
                        write_busy_q <= 1'b1;
                    end
                end
                eeprom_i2c_pkg::W_PROG: begin
                    if (timer_q == 32'h0) begin
                        wstate_q <= eeprom_i2c_pkg::W_IDLE;
                        write_busy_q <= 1'b0;
                        done_tgl_q <= ~done_tgl_q;
                    end else begin
                        timer_q <= timer_q - 32'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (commit) begin
            for (int c = 0; c < PAGE_BYTES; c++) begin
                if (pvalid_q[c]) begin
                    mem_q[{addr_q[ADDR_W-1:PAGE_W], PAGE_W'(c)}] <= pbuf_q[c];
                end
            end
        end
    end

    assign write_busy = write_busy_q;

    // ****************************************
    // Checks
    // ****************************************
    chk_wp_no_arm: assert property (@(posedge scl) disable iff (rst)
        protect_q |-> !armed_q)
        else $error("protected write armed a commit");
    chk_wp_data_nack: assert property (@(posedge scl) disable iff (rst)
        (state_q == eeprom_i2c_pkg::L_WDATA && bit_cnt_q == eeprom_i2c_pkg::BIT_ACK &&
        protect_q) |-> !sda_oe_q)
        else $error("protected data byte was acknowledged");
    chk_sel_reject: assert property (@(posedge scl) disable iff (rst)
        (state_q == eeprom_i2c_pkg::L_SEL && bit_cnt_q == eeprom_i2c_pkg::BIT_LAST &&
        !start_pend && !sel_match(full, ce_s2_q)) |=> state_q == eeprom_i2c_pkg::L_IDLE)
        else $error("mismatched select not released");
    chk_sel_ack: assert property (@(posedge scl) disable iff (rst)
        (state_q == eeprom_i2c_pkg::L_SEL && bit_cnt_q == eeprom_i2c_pkg::BIT_ACK)
        |-> sda_oe_q)
        else $error("matched select not acknowledged");
    chk_lock_silent: assert property (@(posedge scl) disable iff (rst)
        lock_q |-> (state_q == eeprom_i2c_pkg::L_IDLE && !sda_oe_q))
        else $error("device active during write cycle");
    chk_rd_nack_end: assert property (@(posedge scl) disable iff (rst)
        (state_q == eeprom_i2c_pkg::L_RDATA && bit_cnt_q == eeprom_i2c_pkg::BIT_ACK &&
        sda_i && !start_pend) |=> state_q == eeprom_i2c_pkg::L_IDLE)
        else $error("read went on after NoAck");
    chk_rd_addr_step: assert property (@(posedge scl) disable iff (rst)
        (state_q == eeprom_i2c_pkg::L_RDATA && bit_cnt_q == eeprom_i2c_pkg::BIT_LAST &&
        !start_pend) |=> addr_q == addr_next($past(addr_q)))
        else $error("read address did not step by one");
    chk_addr_load: assert property (@(posedge scl) disable iff (rst)
        (state_q == eeprom_i2c_pkg::L_ADDRL && bit_cnt_q == eeprom_i2c_pkg::BIT_LAST &&
        !start_pend) |=> addr_q == $past(addr_full[ADDR_W-1:0]))
        else $error("address not loaded from two bytes");
    chk_arm_slot: assert property (@(posedge scl) disable iff (rst)
        $rose(armed_q) |-> $past(state_q == eeprom_i2c_pkg::L_WDATA &&
        bit_cnt_q == eeprom_i2c_pkg::BIT_ACK))
        else $error("write armed outside slot ten");
    chk_commit_busy: assert property (@(posedge ref_clk) disable iff (rst)
        commit |=> write_busy_q ##0 timer_q == 32'(PROG_CYCLES - 1))
        else $error("commit did not start write cycle");
    chk_busy_end: assert property (@(posedge ref_clk) disable iff (rst)
        (write_busy_q && timer_q == 32'h0) |=> !write_busy_q && $changed(done_tgl_q))
        else $error("write cycle end not reported");
    chk_rst_idle: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(rst) |-> (!write_busy_q && wstate_q == eeprom_i2c_pkg::W_IDLE))
        else $error("not idle after reset");
    cov_commit: cover property (@(posedge ref_clk) disable iff (rst) commit);
    cov_wp_nack: cover property (@(posedge scl) disable iff (rst)
        state_q == eeprom_i2c_pkg::L_WDATA && bit_cnt_q == eeprom_i2c_pkg::BIT_ACK && protect_q);
    cov_rd_end: cover property (@(posedge scl) disable iff (rst)
        state_q == eeprom_i2c_pkg::L_RDATA && bit_cnt_q == eeprom_i2c_pkg::BIT_ACK && sda_i);
    cov_poll_lock: cover property (@(posedge scl) disable iff (rst) lock_q && start_pend);
endmodule : serial_eeprom_i2c_slave

// ==== verif/i2c_master_model.sv ====
// Purpose: Behavioural I2C bus master facing the EEPROM slave
// Assumes: SDA is open drain with a pull-up; SCL period 15 ns
// Notes: SCL stands high between frames
module i2c_master_model (
    output logic scl,
    output logic sda_oe_m,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 10ps;
    initial begin
        scl = 1'b1;
        sda_oe_m = 1'b0;
    end
    // ****************************************
    // Bus conditions
    // ****************************************
    task automatic start();
        if (scl === 1'b0) begin
            #3.75 sda_oe_m = 1'b0;
            #3.75 scl = 1'b1;
        end
        #7.5 sda_oe_m = 1'b1;
        #7.5 scl = 1'b0;
    endtask : start
    task automatic stop();
        #3.75 sda_oe_m = 1'b1;
        #3.75 scl = 1'b1;
        #7.5 sda_oe_m = 1'b0;
        #7.5;
    endtask : stop
    // ****************************************
    // Bits and bytes
    // ****************************************
    task automatic bit_put(input logic b);
        #3.75 sda_oe_m = ~b;
        #3.75 scl = 1'b1;
        #7.5 scl = 1'b0;
    endtask : bit_put
    task automatic bit_get(output logic b);
        #3.75 sda_oe_m = 1'b0;
        #3.75 scl = 1'b1;
        #3.75 b = sda;
        #3.75 scl = 1'b0;
    endtask : bit_get
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) bit_put(d[i]);
        bit_get(a);
        ack = ~a;
    endtask : wr_byte
    task automatic rd_byte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) bit_get(d[i]);
        bit_put(last);
    endtask : rd_byte
endmodule : i2c_master_model

// ==== verif/test_serial_eeprom_i2c_slave.sv ====
// Purpose: Self-checking bench of the EEPROM slave
// Assumes: Strap pins 3'h5, protect pin floating modelled as 0
// Notes: Write time shortened to 20 cycles
module test_serial_eeprom_i2c_slave;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] SEL_W = {eeprom_i2c_pkg::TYPE_ID_DEF, 3'h5, 1'b0};
    localparam logic [7:0] SEL_R = SEL_W | 8'h01;
    logic ref_clk = 1'b0;
    logic rst;
    logic [2:0] ce_pins = 3'h5;
    logic write_protect_n = 1'b0;
    logic sda_o, sda_oe, write_busy, scl, sda_oe_m, ack;
    logic [7:0] d;
    int n_mismatch = 0;
    int checks = 0;
    wire sda = (sda_oe ? sda_o : 1'b1) & ~sda_oe_m;
    always #50 ref_clk = ~ref_clk;
    serial_eeprom_i2c_slave #(.PROG_CYCLES(20)) serial_eeprom_i2c_slave_inst (
        .ref_clk(ref_clk), .rst(rst), .scl(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .write_protect_n(write_protect_n), .chip_sel_bit0(ce_pins[0]),
        .chip_sel_bit1(ce_pins[1]), .chip_sel_bit2(ce_pins[2]), .write_busy(write_busy));
    i2c_master_model i2c_master_model_inst (.scl(scl), .sda_oe_m(sda_oe_m), .sda(sda));
    // ****************************************
    // Checking and closing
    // ****************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic complete_run();
        $display("mismatches=%0d checks=%0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run
    // ****************************************
    // Transfers
    // ****************************************
    task automatic hdr(input logic [15:0] a);
        logic [7:0] b [3] = '{SEL_W, a[15:8], a[7:0]};
        i2c_master_model_inst.start();
        for (int i = 0; i < 3; i++) begin
            i2c_master_model_inst.wr_byte(b[i], ack);
            chk(8'(ack), 8'h01);
        end
    endtask : hdr
    task automatic wait_busy();
        int k = 0;
        while (write_busy !== 1'b1 && k < 50) begin
            @(negedge ref_clk);
            k++;
        end
        chk(8'(write_busy), 8'h01);
        if (k >= 50) complete_run();
        // Polling during the write cycle must go unanswered
        i2c_master_model_inst.start();
        i2c_master_model_inst.wr_byte(SEL_W, ack);
        chk(8'(ack), 8'h00);
        i2c_master_model_inst.stop();
        k = 0;
        while (write_busy !== 1'b0 && k < 100) begin
            @(negedge ref_clk);
            k++;
        end
        chk(8'(write_busy), 8'h00);
        if (k >= 100) complete_run();
        // First frame after the cycle only clears the lock, so poll for an ack
        k = 0;
        ack = 1'b0;
        while (ack !== 1'b1 && k < 4) begin
            i2c_master_model_inst.start();
            i2c_master_model_inst.wr_byte(SEL_W, ack);
            i2c_master_model_inst.stop();
            k++;
        end
        chk(8'(ack), 8'h01);
        if (ack !== 1'b1) complete_run();
    endtask : wait_busy
    task automatic do_write(input logic [15:0] a, input int n, input logic [7:0] d0,
                            input logic [7:0] d1, input logic ok);
        hdr(a);
        for (int i = 0; i < n; i++) begin
            i2c_master_model_inst.wr_byte(i == 0 ? d0 : d1, ack);
            chk(8'(ack), 8'(ok));
        end
        i2c_master_model_inst.stop();
        if (ok) wait_busy();
        else repeat (30) @(negedge ref_clk) chk(8'(write_busy), 8'h00);
    endtask : do_write
    task automatic rd_at(input logic [15:0] a, input int n, input logic [7:0] e [3]);
        hdr(a);
        i2c_master_model_inst.start();
        i2c_master_model_inst.wr_byte(SEL_R, ack);
        chk(8'(ack), 8'h01);
        for (int i = 0; i < n; i++) begin
            i2c_master_model_inst.rd_byte(i == n - 1, d);
            chk(d, e[i]);
        end
        i2c_master_model_inst.stop();
    endtask : rd_at
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        // Rising edge clears the flops on SCL and SDA
        rst = 1'b1;
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk) rst = 1'b0;
        chk(8'({sda_oe, write_busy}), 8'h00);
        @(negedge ref_clk);
        do_write(16'h0123, 1, 8'hA5, 8'h00, 1'b1);
        do_write(16'h0FFE, 2, 8'h11, 8'h22, 1'b1);
        do_write(16'h0000, 2, 8'h5C, 8'h6D, 1'b1);
        rd_at(16'hF123, 1, '{8'hA5, 8'h00, 8'h00});
        rd_at(16'h0FFE, 3, '{8'h11, 8'h22, 8'h5C});
        // Current address read picks up after the wrap
        i2c_master_model_inst.start();
        i2c_master_model_inst.wr_byte(SEL_R, ack);
        chk(8'(ack), 8'h01);
        i2c_master_model_inst.rd_byte(1'b1, d);
        chk(d, 8'h6D);
        i2c_master_model_inst.stop();
        @(negedge ref_clk) write_protect_n = 1'b1;
        do_write(16'h0123, 1, 8'hFF, 8'h00, 1'b0);
        rd_at(16'h0123, 1, '{8'hA5, 8'h00, 8'h00});
        @(negedge ref_clk) write_protect_n = 1'b0;
        // Stop in slot ten after the address, with no data byte
        hdr(16'h0123);
        i2c_master_model_inst.stop();
        repeat (30) @(negedge ref_clk) chk(8'(write_busy), 8'h00);
        // Straps moved to match, then wrong enable bits, then wrong type code
        for (int i = 0; i < 3; i++) begin
            @(negedge ref_clk) ce_pins = (i == 0) ? 3'h7 : 3'h5;
            i2c_master_model_inst.start();
            i2c_master_model_inst.wr_byte(SEL_W ^ (i == 2 ? 8'h80 : 8'h04), ack);
            chk(8'(ack), 8'(i == 0));
            i2c_master_model_inst.stop();
        end
        // Reset in mid-frame, after the select ack slot, leaves SDA undriven
        i2c_master_model_inst.start();
        i2c_master_model_inst.wr_byte(SEL_W, ack);
        chk(8'(ack), 8'h01);
        @(negedge ref_clk) rst = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk(8'({sda_oe, write_busy}), 8'h00);
        rst = 1'b0;
        i2c_master_model_inst.stop();
        @(negedge ref_clk);
        rd_at(16'h0123, 1, '{8'hA5, 8'h00, 8'h00});
        complete_run();
    end
endmodule : test_serial_eeprom_i2c_slave
